// >>> rtl/standby_and_reset_control.v
/*
 standby and reset control for a small 4-bit controller: stop and halt
 states, peripheral clock gating, wake-up, and reset state loading.
 assumes pclk-synchronous inputs, a program memory read port with one
 cycle latency, and an apb master driving the registers.
*/
// Overview of operation
// - stop instruction enters stop state, halt instruction enters halt state.
// - stop entry only when the main system clock is selected.
// - halt entry allowed with main or subsystem clock selected.
// - stop halts main oscillator; halt gates cpu clock only.
// - interval timer stops in stop, keeps counting in halt while the main clock runs.
// - serial runs in stop only with external shift clock.
// - timer counts in stop only with external count pin.
// - watch timer runs in stop only on subsystem clock.
// - display runs in stop only on subsystem clock.
// - external interrupts one, two, four detect in standby; zero does not.
// - standby ends on enabled interrupt request or reset.
// - in halt with main clock stopped, timer freezes; serial, event counter freeze unless externally clocked.
// - reset loads program counter from program words zero and one.
// - reset loads bank enable from word zero bit 7, clears bank select.
// - reset clears skip and interrupt state flags; stack pointer undefined.
// - standby reset keeps data memory, carry, registers; else invalid.
// - serial shift and slave address kept only on standby reset.
// - reset clears request, enable, master enable and edge modes.
// - reset clears clock control, clock output, timer mode registers.
// - reset clears display mode and display control registers.
// - reset turns port buffers off and clears latches and modes.
// - bit manipulation buffer kept only on standby reset.
`include "standby_map.vh"
`timescale 1ns/1ns
`default_nettype none
module standby_and_reset_control
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire stop_instr,
	input wire halt_instr,
	input wire [7:0] irq_event,
	input wire [7:0] pmem_data,
	output reg [13:0] pmem_addr,
	output wire cpu_clk_en,
	output wire main_osc_en,
	output wire sub_osc_en,
	output wire interval_timer_en,
	output wire serial_en,
	output wire timer_en,
	output wire watch_en,
	output wire display_en,
	output wire ext_int0_en,
	output wire ext_int124_en,
	output reg [13:0] program_counter,
	output reg bank_enable_flag,
	output reg [3:0] bank_select_register,
	output reg [2:0] skip_flags,
	output reg [1:0] interrupt_state_flag,
	output reg state_valid,
	output reg state_retained,
	output reg boot_done,
	output reg [7:0] interval_timer_request_flag,
	output reg master_interrupt_enable,
	output reg [7:0] irq_enable,
	output reg [5:0] external_irq_edge_modes,
	output reg [3:0] processor_clock_control,
	output reg [3:0] system_clock_control,
	output reg [3:0] clock_output_mode,
	output reg [3:0] interval_timer_mode,
	output reg [7:0] watch_timer_mode,
	output reg [3:0] display_mode_register,
	output reg [3:0] display_control_register,
	output reg [7:0] serial_mode_register,
	output reg [7:0] serial_bus_control,
	output reg port_output_enable,
	output reg [7:0] port_output_latch,
	output reg [15:0] port_mode_registers,
	output reg [7:0] pull_up_select_register
);
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [1:0] boot_r;
	reg [5:0] clksrc_r;
	reg was_standby_r;
	wire wr_en;
	wire rd_en;
	wire in_stop;
	wire in_halt;
	wire main_running;
	wire [7:0] live_mask;
	wire [7:0] irq_req_nxt;
	wire wake;
	wire in_run;
	wire [7:0] irq_clr;
	reg [4:0] wr_sel;
	reg [31:0] prdata_nxt;
	genvar g;

	// bit positions of the one-hot write select
	localparam WS_CTRL = 0;
	localparam WS_CLKSRC = 1;
	localparam WS_IRQ_EN = 2;
	localparam WS_IRQ_REQ = 3;
	localparam WS_CFG = 4;

	function hit;
		input [11:0] a;
		input [11:0] ofs;
		begin
			hit = (a[11:2] == ofs[11:2]);
		end
	endfunction

	// a peripheral runs while the main clock runs or on its own clock
	function run_in_stop;
		input main_on;
		input own_clock;
		begin
			run_in_stop = main_on | own_clock;
		end
	endfunction

	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pslverr = 1'b0;

	// one write select per writable register; status, boot and unmapped words select none
	always @*
	begin
		wr_sel = 5'b00000;
		if (wr_en)
		begin
			if (hit(paddr, `OFS_CTRL))
				wr_sel[WS_CTRL] = 1'b1;
			else if (hit(paddr, `OFS_CLKSRC))
				wr_sel[WS_CLKSRC] = 1'b1;
			else if (hit(paddr, `OFS_IRQ_EN))
				wr_sel[WS_IRQ_EN] = 1'b1;
			else if (hit(paddr, `OFS_IRQ_REQ))
				wr_sel[WS_IRQ_REQ] = 1'b1;
			else if (hit(paddr, `OFS_CFG))
				wr_sel[WS_CFG] = 1'b1;
		end
	end

	assign in_stop = state_r[2];
	assign in_halt = state_r[1];
	assign in_run = state_r[0];
	// main clock stops in stop or by software
	assign main_running = ~in_stop & ~clksrc_r[`CLK_MAIN_STOP_BIT];

	assign cpu_clk_en = in_run & boot_done;
	assign main_osc_en = ~in_stop & ~clksrc_r[`CLK_MAIN_STOP_BIT];
	assign sub_osc_en = 1'b1;
	// halt with main clock stopped freezes it too
	assign interval_timer_en = main_running;
	assign serial_en = run_in_stop(main_running,
		clksrc_r[`CLK_SCK_EXT_BIT]);
	assign timer_en = run_in_stop(main_running,
		clksrc_r[`CLK_TIN_EXT_BIT]);
	assign watch_en = run_in_stop(main_running,
		clksrc_r[`CLK_WATCH_SUB_BIT]);
	assign display_en = run_in_stop(main_running,
		clksrc_r[`CLK_DISP_SUB_BIT]);
	// external interrupt zero dead in standby
	assign ext_int0_en = in_run;
	assign ext_int124_en = 1'b1;

	// only sources still clocked may raise a request
	assign live_mask[`IRQ_BT] = interval_timer_en;
	assign live_mask[`IRQ_INT4] = 1'b1;
	assign live_mask[`IRQ_INT0] = ext_int0_en;
	assign live_mask[`IRQ_INT1] = 1'b1;
	assign live_mask[`IRQ_CSI] = serial_en;
	assign live_mask[`IRQ_T0] = timer_en;
	assign live_mask[`IRQ_INT2] = 1'b1;
	assign live_mask[`IRQ_W] = watch_en;

	// write one to clear a request flag
	assign irq_clr = wr_sel[WS_IRQ_REQ] ? pwdata[7:0] : 8'h00;

	// set wins over a software clear in the same cycle
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : req_bit
			assign irq_req_nxt[g] = (irq_event[g] & live_mask[g]) |
				(interval_timer_request_flag[g] & ~irq_clr[g]);
		end
	endgenerate

	// enabled request from live hardware ends standby
	assign wake = |(interval_timer_request_flag & irq_enable);

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			`ST_RUN:
			begin
				// stop only on main system clock
				if (stop_instr && boot_done &&
					!clksrc_r[`CLK_SUBSYS_BIT])
					state_nxt = `ST_STOP;
				else if (halt_instr && boot_done)
					state_nxt = `ST_HALT;
			end
			`ST_HALT:
			begin
				if (wake)
					state_nxt = `ST_RUN;
			end
			`ST_STOP:
			begin
				if (wake)
					state_nxt = `ST_RUN;
			end
			default:
				state_nxt = `ST_RUN;
		endcase
	end

	// remembers whether the last reset hit during standby; frozen while
	// reset is low, because the state register clears at once
	always @(posedge pclk)
	begin
		if (presetn)
			was_standby_r <= in_stop | in_halt;
	end

	// reset overrides pending wake by asynchronous clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= `ST_RUN;
			boot_r <= 2'b00;
			boot_done <= 1'b0;
			pmem_addr <= `VEC_WORD0;
			program_counter <= 14'h0000;
			bank_enable_flag <= 1'b0;
			bank_select_register <= 4'h0;
			skip_flags <= 3'b000;
			interrupt_state_flag <= 2'b00;
			state_valid <= 1'b0;
			interval_timer_request_flag <= 8'h00;
			irq_enable <= 8'h00;
			master_interrupt_enable <= 1'b0;
			external_irq_edge_modes <= 6'h00;
			processor_clock_control <= 4'h0;
			system_clock_control <= 4'h0;
			clock_output_mode <= 4'h0;
			interval_timer_mode <= 4'h0;
			watch_timer_mode <= 8'h00;
			display_mode_register <= 4'h0;
			display_control_register <= 4'h0;
			// serial mode and bus control cleared
			serial_mode_register <= 8'h00;
			serial_bus_control <= 8'h00;
			port_output_enable <= 1'b0;
			port_output_latch <= 8'h00;
			port_mode_registers <= 16'h0000;
			pull_up_select_register <= 8'h00;
			clksrc_r <= 6'h00;
		end
		else
		begin
			state_r <= state_nxt;
			interval_timer_request_flag <= irq_req_nxt;
			// vector fetch, word zero then word one
			if (!boot_done)
			begin
				boot_r <= boot_r + 2'b01;
				pmem_addr <= `VEC_WORD1;
				if (boot_r == 2'b01)
				begin
					program_counter[13:8] <= pmem_data[5:0];
					bank_enable_flag <= pmem_data[`MBE_BIT];
				end
				if (boot_r == 2'b10)
				begin
					program_counter[7:0] <= pmem_data;
					boot_done <= 1'b1;
				end
			end
			if (wr_en)
			begin
				if (wr_sel[WS_CTRL])
					master_interrupt_enable <= pwdata[`CTRL_IME_BIT];
				else if (wr_sel[WS_CLKSRC])
					clksrc_r <= pwdata[5:0];
				else if (wr_sel[WS_IRQ_EN])
					irq_enable <= pwdata[7:0];
				else if (wr_sel[WS_CFG])
				begin
					processor_clock_control <= pwdata[3:0];
					system_clock_control <= pwdata[7:4];
					clock_output_mode <= pwdata[11:8];
					interval_timer_mode <= pwdata[15:12];
					display_mode_register <= pwdata[19:16];
					display_control_register <= pwdata[23:20];
					external_irq_edge_modes <= pwdata[29:24];
					port_output_enable <= pwdata[30];
				end
			end
		end
	end

	// retained contents valid only after a standby reset
	// serial shift and slave address follow the same flag
	// bit buffer follows the same flag
	always @(posedge pclk)
	begin
		if (!presetn)
			state_retained <= was_standby_r;
	end

	// apb read mux; unmapped words read as zero
	always @*
	begin
		prdata_nxt = 32'h00000000;
		if (hit(paddr, `OFS_CTRL))
			prdata_nxt = {29'h0, master_interrupt_enable, 2'b00};
		else if (hit(paddr, `OFS_STATUS))
			prdata_nxt = {27'h0, state_retained, boot_done, state_r};
		else if (hit(paddr, `OFS_CLKSRC))
			prdata_nxt = {26'h0, clksrc_r};
		else if (hit(paddr, `OFS_IRQ_EN))
			prdata_nxt = {24'h0, irq_enable};
		else if (hit(paddr, `OFS_IRQ_REQ))
			prdata_nxt = {24'h0, interval_timer_request_flag};
		else if (hit(paddr, `OFS_BOOT))
			prdata_nxt = {17'h0, bank_enable_flag, program_counter};
		else if (hit(paddr, `OFS_CFG))
			prdata_nxt = {1'b0, port_output_enable,
				external_irq_edge_modes, display_control_register,
				display_mode_register, interval_timer_mode,
				clock_output_mode, system_clock_control,
				processor_clock_control};
	end

	// read data is registered in the setup cycle and stands through
	// the access cycle, so the slave never needs a wait state
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_en)
			prdata <= prdata_nxt;
	end
endmodule
`default_nettype wire

// >>> include/standby_map.vh
/*
 standby and reset control constants: register offsets, field positions,
 state encodings and vector locations.
 assumes a 32-bit apb slave with word-aligned registers.
*/
`ifndef STANDBY_MAP_VH
`define STANDBY_MAP_VH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CLKSRC 12'h008
`define OFS_IRQ_EN 12'h00c
`define OFS_IRQ_REQ 12'h010
`define OFS_BOOT 12'h014
`define OFS_CFG 12'h018
`define CTRL_STOP_BIT 0
`define CTRL_HALT_BIT 1
`define CTRL_IME_BIT 2
`define CLK_SUBSYS_BIT 0
`define CLK_MAIN_STOP_BIT 1
`define CLK_SCK_EXT_BIT 2
`define CLK_TIN_EXT_BIT 3
`define CLK_WATCH_SUB_BIT 4
`define CLK_DISP_SUB_BIT 5
`define IRQ_BT 0
`define IRQ_INT4 1
`define IRQ_INT0 2
`define IRQ_INT1 3
`define IRQ_CSI 4
`define IRQ_T0 5
`define IRQ_INT2 6
`define IRQ_W 7
`define VEC_WORD0 14'h0000
`define VEC_WORD1 14'h0001
`define MBE_BIT 7
`define ST_RUN 3'b001
`define ST_HALT 3'b010
`define ST_STOP 3'b100
`endif

// >>> tb/pmem_model.sv
/* program memory stand-in holding the two boot words.
 assumes the design reads it with one cycle of latency. */
`timescale 1ns/1ns
`default_nettype none
module pmem_model
(
	input wire logic pclk,
	input wire logic [13:0] pmem_addr,
	input wire logic [7:0] w0,
	input wire logic [7:0] w1,
	output logic [7:0] pmem_data = 8'h3c
);
	always @(posedge pclk)
		pmem_data <= (pmem_addr == 14'h0) ? w0 :
			(pmem_addr == 14'h1) ? w1 : ~pmem_data;
endmodule
`default_nettype wire

// >>> tb/standby_and_reset_control_monitor.sv
/* port checker for standby_and_reset_control.
 assumes a bind onto the top module; one clock, pclk. */
`timescale 1ns/1ns
`default_nettype none
module standby_and_reset_control_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stop_instr,
	input wire logic halt_instr,
	input wire logic cpu_clk_en,
	input wire logic main_osc_en,
	input wire logic sub_osc_en,
	input wire logic interval_timer_en,
	input wire logic ext_int0_en,
	input wire logic ext_int124_en,
	input wire logic boot_done,
	input wire logic master_interrupt_enable,
	input wire logic [7:0] irq_enable,
	input wire logic [7:0] interval_timer_request_flag
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_release;
		$rose(presetn);
	endsequence
	sequence s_boot;
		!boot_done ##[1:4] (boot_done && cpu_clk_en);
	endsequence
	a_sub_osc_on: assert property (sub_osc_en)
		else $error("sub oscillator off");
	a_int124_live: assert property (ext_int124_en)
		else $error("int 1 2 4 detect off");
	a_int0_standby: assert property (
		boot_done && !cpu_clk_en |-> !ext_int0_en)
		else $error("int0 live in standby");
	a_bt_main_off: assert property (
		!main_osc_en |-> !interval_timer_en)
		else $error("interval timer runs without main clock");
	a_entry_cause: assert property (
		boot_done && $fell(cpu_clk_en) |->
		$past(stop_instr) || $past(halt_instr))
		else $error("standby without instruction");
	a_halt_osc_keep: assert property (
		$fell(cpu_clk_en) && !$past(stop_instr) |-> $stable(main_osc_en))
		else $error("halt touched main oscillator");
	a_wake_bound: assert property (
		boot_done && !cpu_clk_en &&
		(interval_timer_request_flag & irq_enable) != 8'h00 |->
		##[0:2] cpu_clk_en)
		else $error("enabled request did not wake");
	a_boot_order: assert property (s_release |-> s_boot)
		else $error("boot load late");
	a_reset_clear: assert property (
		s_release |-> !master_interrupt_enable &&
		irq_enable == 8'h00 && interval_timer_request_flag == 8'h00)
		else $error("interrupt state not cleared");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/* self-checking bench for standby_and_reset_control.
 assumes pmem_model as program memory; apb driven here. */
`timescale 1ns/1ns
`default_nettype none
`include "standby_map.vh"
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic stop_instr = 0, halt_instr = 0, pready, pslverr, cpu_clk_en;
	logic main_osc_en, sub_osc_en, interval_timer_en, serial_en, timer_en;
	logic watch_en, display_en, ext_int0_en, ext_int124_en, boot_done;
	logic bank_enable_flag, state_valid, state_retained;
	logic master_interrupt_enable, port_output_enable;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, r;
	logic [13:0] pmem_addr, program_counter;
	logic [7:0] irq_event = 0, pmem_data, w0, w1, irq_enable;
	logic [7:0] interval_timer_request_flag, watch_timer_mode;
	logic [7:0] serial_mode_register, serial_bus_control;
	logic [7:0] port_output_latch, pull_up_select_register;
	logic [3:0] bank_select_register, processor_clock_control;
	logic [3:0] system_clock_control, clock_output_mode;
	logic [3:0] interval_timer_mode, display_mode_register;
	logic [3:0] display_control_register;
	logic [2:0] skip_flags;
	logic [1:0] interrupt_state_flag;
	logic [5:0] external_irq_edge_modes, c;
	logic [15:0] port_mode_registers;
	int failures = 0, check_count = 0;
	standby_and_reset_control dut (.*);
	pmem_model pm (.pclk(pclk), .pmem_addr(pmem_addr), .w0(w0), .w1(w1),
		.pmem_data(pmem_data));
	always #5 pclk = ~pclk;
	task report_and_stop;
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 0;
		penable <= 0;
		#1;
	endtask
	task rst;
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (5) @(posedge pclk);
		#1;
	endtask
	// k bit0 requests stop, bit1 requests halt
	task go(input logic [1:0] k);
		@(posedge pclk);
		stop_instr <= k[0];
		halt_instr <= k[1];
		@(posedge pclk);
		stop_instr <= 0;
		halt_instr <= 0;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task ev(input int n);
		@(posedge pclk);
		irq_event <= 8'h01 << n;
		@(posedge pclk);
		irq_event <= 0;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	initial
	begin
		void'($urandom(8));
		r = $urandom;
		w0 = r[7:0];
		w1 = r[15:8];
		rst;
		chk(program_counter, {w0[5:0], w1});
		chk({bank_enable_flag, bank_select_register}, {w0[7], 4'h0});
		chk({skip_flags, interrupt_state_flag}, 0);
		apb(0, 12'h0fc, 0);
		chk(q, 0);
		apb(1, `OFS_CTRL, 32'h4);
		apb(1, `OFS_IRQ_EN, 32'hff);
		apb(1, `OFS_CFG, $urandom);
		rst;
		chk(state_retained, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'h09);
		chk(|{master_interrupt_enable, irq_enable, external_irq_edge_modes}, 0);
		chk(|{processor_clock_control, system_clock_control, clock_output_mode,
			interval_timer_mode, watch_timer_mode}, 0);
		chk(|{display_mode_register, display_control_register}, 0);
		chk({port_output_enable, |{port_output_latch, port_mode_registers,
			pull_up_select_register}}, 2'b00);
		chk(|{serial_mode_register, serial_bus_control}, 0);
		apb(1, `OFS_IRQ_EN, 32'h1 << `IRQ_INT4);
		repeat (4)
		begin
			r = $urandom;
			c = {r[3:0], 2'b00};
			apb(1, `OFS_CLKSRC, c);
			go(1);
			apb(0, `OFS_STATUS, 0);
			chk(q[2:0], `ST_STOP);
			chk({main_osc_en, cpu_clk_en, interval_timer_en}, 0);
			chk({display_en, watch_en, timer_en, serial_en}, c[5:2]);
			ev(`IRQ_INT4);
			chk(cpu_clk_en, 1);
			apb(1, `OFS_IRQ_REQ, 32'hff);
		end
		apb(1, `OFS_CLKSRC, 32'h1);
		go(1);
		apb(0, `OFS_STATUS, 0);
		chk(q[2:0], `ST_RUN);
		go(2);
		apb(0, `OFS_STATUS, 0);
		chk(q[2:0], `ST_HALT);
		chk({main_osc_en, interval_timer_en, cpu_clk_en}, 3'b110);
		ev(`IRQ_INT4);
		apb(1, `OFS_IRQ_REQ, 32'hff);
		apb(1, `OFS_CLKSRC, 32'h3);
		go(2);
		chk({interval_timer_en, serial_en, timer_en}, 0);
		ev(`IRQ_INT4);
		apb(1, `OFS_IRQ_REQ, 32'hff);
		apb(1, `OFS_CLKSRC, 32'h0);
		apb(1, `OFS_IRQ_EN, 32'h1 << `IRQ_INT0);
		go(1);
		ev(`IRQ_INT0);
		chk({cpu_clk_en, ext_int0_en}, 0);
		rst;
		chk(state_retained, 1);
		apb(0, `OFS_STATUS, 0);
		chk(q, 32'h19);
		report_and_stop;
	end
	initial
	begin
		#50000;
		failures++;
		report_and_stop;
	end
endmodule
bind standby_and_reset_control standby_and_reset_control_monitor mon
(
	.pclk(pclk),
	.presetn(presetn),
	.stop_instr(stop_instr),
	.halt_instr(halt_instr),
	.cpu_clk_en(cpu_clk_en),
	.main_osc_en(main_osc_en),
	.sub_osc_en(sub_osc_en),
	.interval_timer_en(interval_timer_en),
	.ext_int0_en(ext_int0_en),
	.ext_int124_en(ext_int124_en),
	.boot_done(boot_done),
	.master_interrupt_enable(master_interrupt_enable),
	.irq_enable(irq_enable),
	.interval_timer_request_flag(interval_timer_request_flag)
);
`default_nettype wire
